//--- gss_spi_slave.sv
// Serial slave interface: mode select and SPI framing
`timescale 1ns/10ps
// Function
// [RULE1] After wait time, slave select low enters 4-wire SPI; mode bit resets 0.
// [RULE2] Slave select high runs two-wire bus; its enable resets to 1.
// [RULE3] Mode bit 1 selects 3-wire SPI and disables two-wire bus.
// [RULE4] Multi-slave option blocks 4-wire, 3-wire and two-wire operation.
// [RULE5] 4-wire uses select, clock, separate in and out, 8-bit units.
// [RULE6] Master keeps mode bit 0 and clears two-wire enable for 4-wire.
// [RULE7] Select falling starts transaction; first byte is address.
// [RULE8] Select rising mid-transfer aborts the transaction.
// [RULE9] Address MSB 0 means write, 1 means read.
// [RULE10] Address bits 6:5 are slave field; master sends 00 normally.
// [RULE11] Address low five bits are register address or command.
// [RULE12] Write loads second byte into addressed register.
// [RULE13] Read shifts data from second byte, changing on clock fall.
// [RULE14] 4-wire output held low whenever no read data is shifted.
// [RULE15] Multi-byte sample reads continue while master keeps clocking.
// [RULE16] Address-only frame with MSB 0 runs command at select rise.
// [RULE17] 3-wire shares one data line, driven only for read data.
// [RULE18] Output pin: 4-wire data, unused 3-wire, strap in two-wire.
// [RULE19] Temperature nominal 25/100/400 at 25 C, slopes 1/4/16.
// [RULE20] Master waits 1 ms after power-up before any transaction.
// [RULE21] MSB first; sample on clock rise, output on clock fall.
module gss_spi_slave import gss_pkg::*; #(
  parameter int WAIT_CYC = GSS_WAIT_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic clk_en,
  // Serial pins
  input wire logic ss_n_pin,
  input wire logic sclk_pin,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  // Configuration
  input wire logic multi_slave_opt,
  input wire logic wire_mode_select,
  input wire logic two_wire_en,
  input wire logic [1:0] temp_res,
  input wire logic signed [11:0] temp_delta,
  // Register port
  output logic reg_wr_stb,
  output logic reg_rd_stb,
  output logic cmd_stb,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Status
  output logic if_ready,
  output logic [1:0] if_mode,
  output logic two_wire_active,
  output logic address_lsb_strap,
  output logic [15:0] temp_out
);
  logic rs1_r, rst_n;
  gss_sync_if sy ();
  logic [15:0] temp_code;
  gss_state_t st_r, st_nxt;
  logic [7:0] sh_r, sh_nxt, tx_r, tx_nxt;
  logic [2:0] bc_r, bc_nxt;
  logic [4:0] ad_r, ad_nxt;
  logic rd_r, rd_nxt, drv_r, drv_nxt, cmd_pend_r, cmd_pend_nxt;
  logic dout_r, dout_nxt;
  logic wr_r, wr_nxt, rds_r, rds_nxt, cmd_r, cmd_nxt;
  logic [7:0] wd_r, wd_nxt;
  logic [13:0] wc_r, wc_nxt;
  logic rdy_r, rdy_nxt, strap_r, strap_nxt;
  logic [15:0] tmp_r;
  gss_if_t md_r, md_nxt;
  logic spi_ok;

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rs1_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rs1_r <= 1'b1;
      rst_n <= rs1_r;
    end
  end

  gss_pin_sync u_sync (
    .clk(sys_clk),
    .rst_n(rst_n),
    .ce(clk_en),
    .ss_n_pin(ss_n_pin),
    .sclk_pin(sclk_pin),
    .mosi_pin(mosi_in),
    .miso_pin(miso_in),
    .so(sy)
  );

  gss_temp_fmt u_temp (
    .res_mode(temp_res),
    .delta_c(temp_delta),
    .temp_code(temp_code) // [RULE19]
  );

  // Power-up wait and mode selection
  always_comb begin
    wc_nxt = wc_r;
    rdy_nxt = rdy_r;
    if (!rdy_r) begin
      if (wc_r == 14'(WAIT_CYC - 1)) rdy_nxt = 1'b1; // [RULE20]
      else wc_nxt = wc_r + 14'h0001;
    end
    strap_nxt = strap_r;
    if (multi_slave_opt) md_nxt = GSS_IF_OFF; // [RULE4]
    else if (!sy.ss_n) md_nxt = wire_mode_select ? GSS_IF_3W
                                                 : GSS_IF_4W; // [RULE1] [RULE3]
    else if (two_wire_en && !wire_mode_select) md_nxt = GSS_IF_2W; // [RULE2]
    else md_nxt = GSS_IF_OFF;
    if (md_nxt == GSS_IF_2W) strap_nxt = sy.strap; // [RULE18]
  end
  assign spi_ok = rdy_r && !multi_slave_opt; // [RULE4]

  // Frame engine
  always_comb begin
    st_nxt = st_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    bc_nxt = bc_r;
    ad_nxt = ad_r;
    rd_nxt = rd_r;
    drv_nxt = drv_r;
    dout_nxt = dout_r;
    cmd_pend_nxt = cmd_pend_r;
    wr_nxt = 1'b0;
    rds_nxt = 1'b0;
    cmd_nxt = 1'b0;
    wd_nxt = wd_r;
    if (sy.ss_rise) begin
      if (cmd_pend_r) cmd_nxt = 1'b1; // [RULE16]
      st_nxt = GSS_ST_IDLE; // [RULE8]
      drv_nxt = 1'b0;
      dout_nxt = 1'b0;
      cmd_pend_nxt = 1'b0;
    end else if (sy.ss_fall && spi_ok) begin
      st_nxt = GSS_ST_ADDR; // [RULE7]
      bc_nxt = 3'h0;
      cmd_pend_nxt = 1'b0;
    end else if (st_r != GSS_ST_IDLE && !sy.ss_n) begin
      if (sy.sclk_rise) begin
        sh_nxt = {sh_r[6:0], sy.mosi}; // [RULE21]
        bc_nxt = bc_r + 3'h1;
        if (st_r == GSS_ST_WDATA) cmd_pend_nxt = 1'b0; // [RULE16]
        if (bc_r == 3'h7) begin // [RULE5] [RULE17]
          case (st_r)
            GSS_ST_ADDR: begin
              rd_nxt = sh_nxt[GSS_DIR_BIT]; // [RULE9]
              ad_nxt = sh_nxt[GSS_ADDR_W-1:0]; // [RULE11]
              if (sh_nxt[GSS_DIR_BIT]) begin
                st_nxt = GSS_ST_RDATA;
                rds_nxt = 1'b1;
              end else begin
                st_nxt = GSS_ST_WDATA;
                cmd_pend_nxt = 1'b1; // [RULE16]
              end
            end
            GSS_ST_WDATA: begin
              wd_nxt = sh_nxt;
              wr_nxt = 1'b1; // [RULE12]
              cmd_pend_nxt = 1'b0;
              st_nxt = GSS_ST_IDLE;
            end
            GSS_ST_RDATA: begin
              ad_nxt = ad_r + 5'h01; // [RULE15]
              rds_nxt = 1'b1;
            end
            default: st_nxt = GSS_ST_IDLE;
          endcase
        end
      end
      if (sy.sclk_fall && st_r == GSS_ST_RDATA) begin
        if (bc_r == 3'h0) begin
          dout_nxt = reg_rdata[7]; // [RULE13] [RULE21]
          tx_nxt = {reg_rdata[6:0], 1'b0};
        end else begin
          dout_nxt = tx_r[7];
          tx_nxt = {tx_r[6:0], 1'b0};
        end
        drv_nxt = 1'b1;
      end
    end
    if (st_nxt != GSS_ST_RDATA) begin
      drv_nxt = 1'b0; // [RULE14]
      dout_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= GSS_ST_IDLE;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      bc_r <= 3'h0;
      ad_r <= 5'h00;
      rd_r <= 1'b0;
      drv_r <= 1'b0;
      dout_r <= 1'b0;
      cmd_pend_r <= 1'b0;
      wr_r <= 1'b0;
      rds_r <= 1'b0;
      cmd_r <= 1'b0;
      wd_r <= 8'h00;
      wc_r <= 14'h0000;
      rdy_r <= 1'b0;
      strap_r <= 1'b0;
      md_r <= GSS_IF_2W;
      tmp_r <= 16'h0000;
    end else if (clk_en) begin
      st_r <= st_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      bc_r <= bc_nxt;
      ad_r <= ad_nxt;
      rd_r <= rd_nxt;
      drv_r <= drv_nxt;
      dout_r <= dout_nxt;
      cmd_pend_r <= cmd_pend_nxt;
      wr_r <= wr_nxt;
      rds_r <= rds_nxt;
      cmd_r <= cmd_nxt;
      wd_r <= wd_nxt;
      wc_r <= wc_nxt;
      rdy_r <= rdy_nxt;
      strap_r <= strap_nxt;
      md_r <= md_nxt;
      tmp_r <= temp_code;
    end
  end

  // Output pins from registers
  logic mo_r, moe_r, so_r, soe_r, tw_r;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mo_r <= 1'b0;
      moe_r <= 1'b0;
      so_r <= 1'b0;
      soe_r <= 1'b0;
      tw_r <= 1'b1;
    end else if (clk_en) begin
      mo_r <= dout_nxt;
      moe_r <= drv_nxt && md_r == GSS_IF_3W; // [RULE17]
      so_r <= (md_r == GSS_IF_4W) ? dout_nxt : 1'b0; // [RULE14]
      soe_r <= md_r == GSS_IF_4W && !sy.ss_n; // [RULE5] [RULE18]
      tw_r <= md_nxt == GSS_IF_2W; // [RULE2]
    end
  end

  assign mosi_out = mo_r;
  assign mosi_oe = moe_r;
  assign miso_out = so_r;
  assign miso_oe = soe_r;
  assign reg_wr_stb = wr_r;
  assign reg_rd_stb = rds_r;
  assign cmd_stb = cmd_r;
  assign reg_addr = ad_r;
  assign reg_wdata = wd_r;
  assign if_ready = rdy_r;
  assign if_mode = md_r;
  assign two_wire_active = tw_r;
  assign address_lsb_strap = strap_r;
  assign temp_out = tmp_r;

  a_abort_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && sy.ss_rise |=> st_r == GSS_ST_IDLE && !drv_r) // [RULE8]
    else $error("frame not aborted");
  a_write_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    wr_r |-> $past(st_r) == GSS_ST_WDATA) // [RULE12]
    else $error("write outside data byte");
  a_cmd_on_rise: assert property (@(posedge sys_clk) disable iff (!rst_n)
    cmd_r |-> $past(sy.ss_rise) && !$past(rd_r)) // [RULE16]
    else $error("command without select rise");
  a_miso_low: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r != GSS_ST_RDATA |=> !miso_out) // [RULE14]
    else $error("output not low");
  a_multi_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
    clk_en && multi_slave_opt |=> if_mode == GSS_IF_OFF) // [RULE4]
    else $error("multi-slave not blocking");
  a_three_wire: assert property (@(posedge sys_clk) disable iff (!rst_n)
    mosi_oe |-> if_mode == GSS_IF_3W) // [RULE17]
    else $error("data line driven off 3-wire");
  a_wait_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r != GSS_ST_IDLE |-> if_ready) // [RULE20]
    else $error("frame before wait");
  a_read_dir: assert property (@(posedge sys_clk) disable iff (!rst_n)
    st_r == GSS_ST_RDATA |-> rd_r) // [RULE9]
    else $error("read state with write bit");
  a_strap_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !two_wire_active |-> $stable(address_lsb_strap)) // [RULE18]
    else $error("strap sampled outside two-wire");
  a_read_strobe: assert property (@(posedge sys_clk) disable iff (!rst_n)
    reg_rd_stb |-> $past(st_r) != GSS_ST_IDLE && rd_r) // [RULE13]
    else $error("read strobe outside read frame");
endmodule // gss_spi_slave

//--- gss_pkg.sv
// Package: constants and types for the serial slave interface
package gss_pkg;
  localparam int GSS_BYTE_W = 8;
  localparam int GSS_ADDR_W = 5;
  localparam int GSS_DIR_BIT = 7;
  localparam int GSS_SEL_HI = 6;
  localparam int GSS_SEL_LO = 5;
  localparam int GSS_CLK_MHZ = 10;
  localparam int GSS_WAIT_US = 1000;
  localparam int GSS_WAIT_CYC = GSS_WAIT_US * GSS_CLK_MHZ;
  localparam logic GSS_WIRE_MODE_RST = 1'b0;
  localparam logic GSS_TWO_WIRE_EN_RST = 1'b1;
  localparam logic [7:0] GSS_TEMP8_NOM = 8'h19;
  localparam logic [11:0] GSS_TEMP10_NOM = 12'h064;
  localparam logic [11:0] GSS_TEMP12_NOM = 12'h190;
  localparam logic [1:0] GSS_TSEN_8 = 2'h0;
  localparam logic [1:0] GSS_TSEN_10 = 2'h1;
  localparam logic [1:0] GSS_TSEN_12 = 2'h2;
  typedef enum logic [1:0] {GSS_IF_4W, GSS_IF_3W, GSS_IF_2W, GSS_IF_OFF}
    gss_if_t;
  typedef enum logic [1:0] {GSS_ST_IDLE, GSS_ST_ADDR, GSS_ST_WDATA,
    GSS_ST_RDATA} gss_state_t;
endpackage

//--- gss_sync_if.sv
// Interface: synchronised pin levels and edge strobes
`timescale 1ns/10ps
interface gss_sync_if;
  logic ss_n;
  logic ss_fall;
  logic ss_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic mosi;
  logic strap;
  modport src (output ss_n, ss_fall, ss_rise, sclk_rise, sclk_fall, mosi,
    strap);
  modport dst (input ss_n, ss_fall, ss_rise, sclk_rise, sclk_fall, mosi,
    strap);
endinterface

//--- gss_pin_sync.sv
// Pin synchronisers and edge detectors
`timescale 1ns/10ps
module gss_pin_sync import gss_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Raw pins
  input wire logic ss_n_pin,
  input wire logic sclk_pin,
  input wire logic mosi_pin,
  input wire logic miso_pin,
  // Synchronised side
  gss_sync_if.src so
);
  logic [3:0] s1_r, s2_r, s3_r, s1_nxt, s2_nxt, s3_nxt;
  always_comb begin
    s1_nxt = {miso_pin, mosi_pin, sclk_pin, ss_n_pin};
    s2_nxt = s1_r;
    s3_nxt = s2_r;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= 4'h1;
      s2_r <= 4'h1;
      s3_r <= 4'h1;
    end else if (ce) begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      s3_r <= s3_nxt;
    end
  end
  assign so.ss_n = s2_r[0];
  assign so.ss_fall = s3_r[0] & ~s2_r[0];
  assign so.ss_rise = ~s3_r[0] & s2_r[0];
  assign so.sclk_rise = ~s3_r[1] & s2_r[1];
  assign so.sclk_fall = s3_r[1] & ~s2_r[1];
  assign so.mosi = s2_r[2];
  assign so.strap = s2_r[3];
endmodule // gss_pin_sync

//--- gss_temp_fmt.sv
// Temperature output scaling per resolution mode
`timescale 1ns/10ps
module gss_temp_fmt import gss_pkg::*; (
  // Inputs
  input wire logic [1:0] res_mode,
  input wire logic signed [11:0] delta_c,
  // Output
  output logic [15:0] temp_code
);
  logic [11:0] v;
  always_comb begin
    case (res_mode)
      GSS_TSEN_8: v = {{4{delta_c[7]}}, GSS_TEMP8_NOM + delta_c[7:0]};
      GSS_TSEN_10: v = GSS_TEMP10_NOM + {delta_c[9:0], 2'b00};
      default: v = GSS_TEMP12_NOM + {delta_c[7:0], 4'h0};
    endcase
    temp_code = {{4{v[11]}}, v};
  end
endmodule // gss_temp_fmt

//--- gss_host_model.sv
// Host SPI master model that drives the serial pins
`timescale 1ns/10ps
module gss_host_model #(
  parameter int HALF = 8
) (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  input wire logic sdi,
  output logic ss_n,
  output logic sclk,
  output logic mosi
);
  initial begin
    ss_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end
  // One frame, tx sent MSB first, sdi taken before each rise
  task automatic frame(input logic [23:0] tx, input int nbits,
    output logic [23:0] rx);
    rx = '0;
    @(posedge sys_clk);
    ss_n <= 1'b0;
    repeat (HALF) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      mosi <= tx[23 - i];
      repeat (HALF - 1) @(posedge sys_clk);
      @(negedge sys_clk);
      rx = {rx[22:0], sdi};
      @(posedge sys_clk);
      sclk <= 1'b1;
      repeat (HALF) @(posedge sys_clk);
      sclk <= 1'b0;
    end
    repeat (HALF) @(posedge sys_clk);
    ss_n <= 1'b1;
    mosi <= ~mosi;
    repeat (2 * HALF) @(posedge sys_clk);
  endtask
endmodule // gss_host_model

//--- tb_top.sv
// Testbench: host frames against the serial slave interface
`timescale 1ns/10ps
module tb_top;
  import gss_pkg::*;
  logic sys_clk, arst_n, h_ss_n, h_sclk, h_mosi, strap_pin;
  logic multi_slave_opt, wire_mode_select, two_wire_en;
  logic mosi_out, mosi_oe, miso_out, miso_oe, data_line, miso_line;
  logic reg_wr_stb, reg_rd_stb, cmd_stb, if_ready, two_wire_active;
  logic address_lsb_strap;
  logic [1:0] if_mode, temp_res;
  logic signed [11:0] temp_delta;
  logic [4:0] reg_addr, wa_r;
  logic [7:0] reg_wdata, reg_rdata, wd_r;
  logic [15:0] temp_out;
  logic [23:0] rx;
  logic [1:0] t_res [3] = '{GSS_TSEN_8, GSS_TSEN_10, GSS_TSEN_12};
  logic signed [11:0] t_dl [3] = '{12'sd0, 12'sd1, -12'sd1};
  logic [15:0] t_exp [3] = '{16'h0019, 16'h0068, 16'h0180};
  int wr_cnt = 0;
  int cmd_cnt = 0;
  int rd_cnt = 0;
  int cyc = 0;
  int mismatches = 0;
  int cmp_count = 0;

  // Shared data line and driven strap level
  assign data_line = mosi_oe ? mosi_out : h_mosi;
  assign miso_line = miso_oe ? miso_out : strap_pin;
  assign reg_rdata = 8'h30 + {3'h0, reg_addr};

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  gss_spi_slave #(.WAIT_CYC(20)) i_gss_spi_slave (
    .sys_clk(sys_clk), .arst_n(arst_n), .clk_en(1'b1),
    .ss_n_pin(h_ss_n), .sclk_pin(h_sclk), .mosi_in(data_line),
    .mosi_out(mosi_out), .mosi_oe(mosi_oe), .miso_in(miso_line),
    .miso_out(miso_out), .miso_oe(miso_oe),
    .multi_slave_opt(multi_slave_opt),
    .wire_mode_select(wire_mode_select), .two_wire_en(two_wire_en),
    .temp_res(temp_res), .temp_delta(temp_delta),
    .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb), .cmd_stb(cmd_stb),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .if_ready(if_ready), .if_mode(if_mode),
    .two_wire_active(two_wire_active),
    .address_lsb_strap(address_lsb_strap), .temp_out(temp_out));

  gss_host_model i_gss_host_model (.sys_clk(sys_clk),
    .sdi(wire_mode_select ? data_line : miso_line), .ss_n(h_ss_n),
    .sclk(h_sclk), .mosi(h_mosi));

  task automatic chk(input string nm, input logic [23:0] e,
    input logic [23:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Strobe capture and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (reg_wr_stb === 1'b1) begin
      wr_cnt <= wr_cnt + 1;
      wa_r <= reg_addr;
      wd_r <= reg_wdata;
    end
    if (cmd_stb === 1'b1) begin
      cmd_cnt <= cmd_cnt + 1;
      wa_r <= reg_addr;
    end
    if (reg_rd_stb === 1'b1) begin
      rd_cnt <= rd_cnt + 1;
    end
    if (cyc == 60000) begin
      mismatches++;
      complete_run;
    end
  end

  initial begin
    arst_n = 1'b0;
    strap_pin = 1'b1;
    multi_slave_opt = 1'b0;
    wire_mode_select = 1'b0;
    two_wire_en = 1'b1;
    temp_res = GSS_TSEN_8;
    temp_delta = 12'sd0;
    repeat (6) @(posedge sys_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < 200 && if_ready !== 1'b1; i++) begin
      @(posedge sys_clk);
    end
    chk("if_ready", 1, if_ready);
    chk("two_wire", 1, two_wire_active);
    chk("if_mode_2w", GSS_IF_2W, if_mode);
    chk("strap", 1, address_lsb_strap);
    two_wire_en <= 1'b0;
    i_gss_host_model.frame(24'h05_a500, 16, rx);
    chk("wr_cnt", 1, wr_cnt);
    chk("wr_addr", 5'h05, wa_r);
    chk("wr_data", 8'ha5, wd_r);
    chk("miso_wr", 0, rx);
    $display("test write done");
    i_gss_host_model.frame(24'h8c_0000, 24, rx);
    chk("rd_data", 24'h00_3c3d, rx);
    chk("rd_stb", 3, rd_cnt);
    $display("test read done");
    i_gss_host_model.frame(24'h1f_0000, 8, rx);
    chk("cmd_cnt", 1, cmd_cnt);
    chk("cmd_code", 5'h1f, wa_r);
    chk("cmd_wr", 1, wr_cnt);
    chk("miso_cmd", 0, rx[7:0]);
    $display("test command done");
    i_gss_host_model.frame(24'h03_5a00, 12, rx);
    chk("abort_part", 1, wr_cnt);
    i_gss_host_model.frame(24'h03_5a00, 16, rx);
    chk("abort_wr", 2, wr_cnt);
    chk("abort_cmd", 1, cmd_cnt);
    chk("abort_data", 8'h5a, wd_r);
    $display("test abort done");
    multi_slave_opt <= 1'b1;
    i_gss_host_model.frame(24'h02_1100, 16, rx);
    chk("multi_wr", 2, wr_cnt);
    chk("multi_mode", GSS_IF_OFF, if_mode);
    $display("test multi-slave done");
    multi_slave_opt <= 1'b0;
    two_wire_en <= 1'b1;
    strap_pin <= 1'b0;
    repeat (6) @(posedge sys_clk);
    chk("strap_low", 0, address_lsb_strap);
    wire_mode_select <= 1'b1;
    strap_pin <= 1'b1;
    repeat (4) @(posedge sys_clk);
    chk("two_wire_3w", 0, two_wire_active);
    chk("strap_3w", 0, address_lsb_strap);
    i_gss_host_model.frame(24'h81_0000, 16, rx);
    chk("rd_3w", 8'h31, rx[7:0]);
    i_gss_host_model.frame(24'h07_c300, 16, rx);
    chk("wr_3w", 8'hc3, wd_r);
    chk("wr_3w_cnt", 3, wr_cnt);
    $display("test three wire done");
    for (int i = 0; i < 3; i++) begin
      temp_res <= t_res[i];
      temp_delta <= t_dl[i];
      repeat (4) @(posedge sys_clk);
      chk("temp_out", t_exp[i], temp_out);
    end
    $display("test temperature done");
    complete_run;
  end
endmodule // tb_top
